// ### hw/pin_function_pkg.sv
// Package: register map, field layout and carriers of the pin function selector
package pin_function_pkg;

  localparam int PIN_COUNT = 12;
  localparam int IDX_W     = 4;
  localparam int FUNC_W    = 8;
  localparam int DATA_W    = 32;
  localparam int WORD_LSB  = 2;

  // Pin positions inside the register array
  localparam int P36 = 0;
  localparam int P37 = 1;
  localparam int P40 = 2;
  localparam int P41 = 3;
  localparam int P42 = 4;
  localparam int P43 = 5;
  localparam int P44 = 6;
  localparam int P45 = 7;
  localparam int P46 = 8;
  localparam int P47 = 9;
  localparam int P56 = 10;
  localparam int P57 = 11;

  // Register indices; byte address is four times the index
  localparam logic [15:0] PORT3_PIN6_FUNCTION_SELECT = 16'ha07e;
  localparam logic [15:0] PORT3_PIN7_FUNCTION_SELECT = 16'ha07f;
  localparam logic [15:0] PORT5_PIN6_FUNCTION_SELECT = 16'ha0be;
  localparam logic [15:0] PORT5_PIN7_FUNCTION_SELECT = 16'ha0bf;
  localparam logic [15:0] PORT4_PIN0_FUNCTION_SELECT = 16'ha0d0;
  localparam logic [15:0] PORT4_PIN1_FUNCTION_SELECT = 16'ha0d1;
  localparam logic [15:0] PORT4_PIN2_FUNCTION_SELECT = 16'ha0d2;
  localparam logic [15:0] PORT4_PIN3_FUNCTION_SELECT = 16'ha0d3;
  localparam logic [15:0] PORT4_PIN4_FUNCTION_SELECT = 16'ha0d4;
  localparam logic [15:0] PORT4_PIN5_FUNCTION_SELECT = 16'ha0d5;
  localparam logic [15:0] PORT4_PIN6_FUNCTION_SELECT = 16'ha0d6;
  localparam logic [15:0] PORT4_PIN7_FUNCTION_SELECT = 16'ha0d7;

  localparam logic [PIN_COUNT-1:0][15:0] PIN_INDEX = {
    PORT5_PIN7_FUNCTION_SELECT, PORT5_PIN6_FUNCTION_SELECT,
    PORT4_PIN7_FUNCTION_SELECT, PORT4_PIN6_FUNCTION_SELECT,
    PORT4_PIN5_FUNCTION_SELECT, PORT4_PIN4_FUNCTION_SELECT,
    PORT4_PIN3_FUNCTION_SELECT, PORT4_PIN2_FUNCTION_SELECT,
    PORT4_PIN1_FUNCTION_SELECT, PORT4_PIN0_FUNCTION_SELECT,
    PORT3_PIN7_FUNCTION_SELECT, PORT3_PIN6_FUNCTION_SELECT};

  // Field positions
  localparam int GENERAL_IO_SELECT            = 0;
  localparam int SPI_DATA_IN_SELECT           = 1;
  localparam int SPI_SERIAL_CLOCK_SELECT      = 1;
  localparam int CEC_LINE_SELECT              = 1;
  localparam int SECOND_SLAVE_DATA_SELECT     = 1;
  localparam int SECOND_SLAVE_CLOCK_SELECT    = 1;
  localparam int WIDE_MODULATOR_OUTPUT_SELECT = 1;
  localparam int CEC_STOP_WAKE_ENABLE         = 2;

  // Implemented bits per register
  localparam logic [7:0] MASK_GPIO = 8'h01;
  localparam logic [7:0] MASK_ALT  = 8'h03;
  localparam logic [7:0] MASK_CEC  = 8'h07;
  localparam logic [PIN_COUNT-1:0][7:0] PIN_MASK = {
    MASK_GPIO, MASK_GPIO, MASK_ALT, MASK_GPIO, MASK_GPIO, MASK_GPIO,
    MASK_ALT, MASK_GPIO, MASK_ALT, MASK_CEC, MASK_ALT, MASK_ALT};
  localparam logic [7:0] FUNC_RESET = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic              hsel;
    logic [DATA_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic              hready;
  } ahb_req_s;

  typedef struct packed {
    logic              hreadyout;
    logic              hresp;
    logic [DATA_W-1:0] hrdata;
  } ahb_rsp_s;

  // Peripheral side toward the pins
  typedef struct packed {
    logic spi_miso_out;
    logic spi_miso_drive;
    logic spi_clk_out;
    logic spi_clk_drive;
    logic cec_drive_low;
    logic sda2_drive_low;
    logic scl2_drive_low;
    logic wide_modulator_output;
  } periph_out_s;

  // Pin levels toward the peripherals
  typedef struct packed {
    logic spi_data_in;
    logic spi_clk_in;
    logic cec_in;
    logic sda2_in;
    logic scl2_in;
  } periph_in_s;

  // Open-drain lines idle released (high)
  localparam periph_in_s PERIPH_IN_IDLE = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  typedef struct packed {
    logic [PIN_COUNT-1:0][FUNC_W-1:0] fn;
    logic                             ph_write;
    logic                             ph_hit;
    logic [IDX_W-1:0]                 ph_idx;
    logic [DATA_W-1:0]                rdata;
    logic [PIN_COUNT-1:0]             pad_out;
    logic [PIN_COUNT-1:0]             pad_oe_n;
    logic [PIN_COUNT-1:0]             gpio_in;
    logic [PIN_COUNT-1:0]             aclose;
    periph_in_s                       pin;
    logic                             wake;
  } state_s;

  localparam state_s STATE_RESET = '{
    fn: '0, ph_write: 1'b0, ph_hit: 1'b0, ph_idx: '0, rdata: '0,
    pad_out: '0, pad_oe_n: '1, gpio_in: '0, aclose: '0,
    pin: PERIPH_IN_IDLE, wake: 1'b0};

endpackage

// ### hw/port_pin_function_select.sv
// Per-pin function selector for ports 3.6-3.7, 4.0-4.7, 5.6-5.7 with AHB-Lite registers
//
// Design decision made here: register access over AHB-Lite.

`timescale 1ns/10ps

module port_pin_function_select (
  // Clock and reset
  input  wire logic                                   MCLK,
  input  wire logic                                   RST_N,
  // Register bus
  input  wire pin_function_pkg::ahb_req_s             AHB_REQ,
  output      pin_function_pkg::ahb_rsp_s             AHB_RSP,
  // Pads
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] PAD_IN,
  output      logic [pin_function_pkg::PIN_COUNT-1:0] PAD_OUT,
  output      logic [pin_function_pkg::PIN_COUNT-1:0] PAD_OE_N,
  // General IO port logic
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] GPIO_OUT,
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] GPIO_DRIVE,
  output      logic [pin_function_pkg::PIN_COUNT-1:0] GPIO_IN,
  // Peripherals
  input  wire pin_function_pkg::periph_out_s          PERIPH_OUT,
  output      pin_function_pkg::periph_in_s           PERIPH_IN,
  output      logic                                   STOP_WAKE,
  // Analog switches
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] ANALOG_SWITCH_ENABLE,
  output      logic [pin_function_pkg::PIN_COUNT-1:0] ANALOG_SWITCH_CLOSE
);
  import pin_function_pkg::*;

  state_s state_q;
  state_s state_d;

  // Address decode, used for both reads and writes
  function automatic logic [IDX_W:0] decode(input logic [DATA_W-1:0] addr);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (addr == (DATA_W'(PIN_INDEX[i]) << WORD_LSB)) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // Alternate source for a pin: {drive, level}
  function automatic logic [1:0] alt_drive(input int i, input periph_out_s po);
    logic [1:0] r;
    r = 2'b00;
    case (i)
      P36: r = {po.spi_miso_drive, po.spi_miso_out};
      P37: r = {po.spi_clk_drive, po.spi_clk_out};
      P40: r = {po.cec_drive_low, 1'b0};
      P41: r = {po.sda2_drive_low, 1'b0};
      P43: r = {po.scl2_drive_low, 1'b0};
      P47: r = {1'b1, po.wide_modulator_output};
      default: r = 2'b00;
    endcase
    return r;
  endfunction

  logic           acc_valid;
  logic [IDX_W:0] dec;
  logic [1:0]     alt;

  always_comb begin
    state_d   = state_q;
    acc_valid = AHB_REQ.hsel && AHB_REQ.hready && (AHB_REQ.htrans == HTRANS_NONSEQ);
    dec       = decode(AHB_REQ.haddr);
    alt       = 2'b00;

    // Data phase of a write; unimplemented bits stay zero
    if (state_q.ph_write && state_q.ph_hit) begin
      state_d.fn[state_q.ph_idx] = AHB_REQ.hwdata[FUNC_W-1:0] & PIN_MASK[state_q.ph_idx];
    end

    // Address phase capture
    state_d.ph_write = acc_valid && AHB_REQ.hwrite;
    state_d.ph_hit   = dec[IDX_W];
    state_d.ph_idx   = dec[IDX_W-1:0];

    // Read data sampled from the updated copy, so a write just before is seen
    if (acc_valid && !AHB_REQ.hwrite && dec[IDX_W]) begin
      state_d.rdata = DATA_W'(state_d.fn[dec[IDX_W-1:0]]);
    end else begin
      state_d.rdata = '0;
    end

    // Pad drive: an alternate function outranks general IO if both are set
    for (int i = 0; i < PIN_COUNT; i++) begin
      alt = alt_drive(i, PERIPH_OUT);
      if (state_q.fn[i][SPI_DATA_IN_SELECT] && PIN_MASK[i][SPI_DATA_IN_SELECT]) begin
        state_d.pad_oe_n[i] = !alt[1];
        state_d.pad_out[i]  = alt[0];
      end else if (state_q.fn[i][GENERAL_IO_SELECT]) begin
        state_d.pad_oe_n[i] = !GPIO_DRIVE[i];
        state_d.pad_out[i]  = GPIO_OUT[i];
      end else begin
        state_d.pad_oe_n[i] = 1'b1;
        state_d.pad_out[i]  = 1'b0;
      end
      state_d.gpio_in[i] = state_q.fn[i][GENERAL_IO_SELECT] && PAD_IN[i];
    end

    // Pin levels toward the peripherals, idle when not selected
    state_d.pin = PERIPH_IN_IDLE;
    if (state_q.fn[P36][SPI_DATA_IN_SELECT]) begin
      state_d.pin.spi_data_in = PAD_IN[P36];
    end
    if (state_q.fn[P37][SPI_SERIAL_CLOCK_SELECT]) begin
      state_d.pin.spi_clk_in = PAD_IN[P37];
    end
    if (state_q.fn[P40][CEC_LINE_SELECT]) begin
      state_d.pin.cec_in = PAD_IN[P40];
    end
    if (state_q.fn[P41][SECOND_SLAVE_DATA_SELECT]) begin
      state_d.pin.sda2_in = PAD_IN[P41];
    end
    if (state_q.fn[P43][SECOND_SLAVE_CLOCK_SELECT]) begin
      state_d.pin.scl2_in = PAD_IN[P43];
    end

    // Wake is a level; the power controller only looks at it in STOP
    state_d.wake = (state_q.fn[P40][CEC_STOP_WAKE_ENABLE] || state_q.fn[P40][CEC_LINE_SELECT])
                   && !PAD_IN[P40];

    // Switch follows the analog enable even if a digital function is on
    state_d.aclose = ANALOG_SWITCH_ENABLE;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign AHB_RSP.hreadyout   = 1'b1;
  assign AHB_RSP.hresp       = HRESP_OKAY;
  assign AHB_RSP.hrdata      = state_q.rdata;
  assign PAD_OUT             = state_q.pad_out;
  assign PAD_OE_N            = state_q.pad_oe_n;
  assign GPIO_IN             = state_q.gpio_in;
  assign PERIPH_IN           = state_q.pin;
  assign STOP_WAKE           = state_q.wake;
  assign ANALOG_SWITCH_CLOSE = state_q.aclose;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  logic [DATA_W-1:0] p36_addr;
  assign p36_addr = DATA_W'(PORT3_PIN6_FUNCTION_SELECT) << WORD_LSB;

  sequence wr_p36_seq;
    AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans == HTRANS_NONSEQ
      && AHB_REQ.hwrite && AHB_REQ.haddr == p36_addr;
  endsequence

  sequence rd_p36_seq;
    AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans == HTRANS_NONSEQ
      && !AHB_REQ.hwrite && AHB_REQ.haddr == p36_addr;
  endsequence

  property wr_p36_prop;
    wr_p36_seq ##1 1'b1 |=> state_q.fn[P36] == ($past(AHB_REQ.hwdata[FUNC_W-1:0]) & MASK_ALT);
  endproperty

  property rd_p36_prop;
    rd_p36_seq |=> AHB_RSP.hrdata == DATA_W'(state_q.fn[P36]);
  endproperty

  reg_write_a: assert property (wr_p36_prop)
    else $error("pin 3.6 register did not take masked write");

  reg_read_a: assert property (rd_p36_prop)
    else $error("pin 3.6 register read back wrong");

  reset_clear_a: assert property ($past(!RST_N) |-> state_q.fn == '0 && PAD_OE_N == '1)
    else $error("function registers not zero after reset");

  miso_route_a: assert property (state_q.fn[P36][SPI_DATA_IN_SELECT]
    |=> PERIPH_IN.spi_data_in == $past(PAD_IN[P36]))
    else $error("pin 3.6 not routed to SPI data in");

  spi_clock_a: assert property (state_q.fn[P37][SPI_SERIAL_CLOCK_SELECT] && PERIPH_OUT.spi_clk_drive
    |=> !PAD_OE_N[P37] && PAD_OUT[P37] == $past(PERIPH_OUT.spi_clk_out))
    else $error("pin 3.7 not driven by SPI clock");

  cec_wake_a: assert property (state_q.fn[P40][CEC_STOP_WAKE_ENABLE] && !PAD_IN[P40]
    |=> STOP_WAKE)
    else $error("low CEC line did not raise wake");

  cec_line_a: assert property (state_q.fn[P40][CEC_LINE_SELECT] && PERIPH_OUT.cec_drive_low
    |=> !PAD_OE_N[P40] && !PAD_OUT[P40])
    else $error("CEC controller cannot pull pin 4.0 low");

  slave_data_a: assert property (state_q.fn[P41][SECOND_SLAVE_DATA_SELECT]
    |=> PERIPH_IN.sda2_in == $past(PAD_IN[P41]) && PAD_OE_N[P41] == !$past(PERIPH_OUT.sda2_drive_low))
    else $error("pin 4.1 not tied to second slave data");

  slave_clock_a: assert property (state_q.fn[P43][SECOND_SLAVE_CLOCK_SELECT]
    |=> PERIPH_IN.scl2_in == $past(PAD_IN[P43]) && PAD_OE_N[P43] == !$past(PERIPH_OUT.scl2_drive_low))
    else $error("pin 4.3 not tied to second slave clock");

  modulator_out_a: assert property (state_q.fn[P47][WIDE_MODULATOR_OUTPUT_SELECT]
    |=> !PAD_OE_N[P47] && PAD_OUT[P47] == $past(PERIPH_OUT.wide_modulator_output))
    else $error("pin 4.7 not driven by modulator");

  gpio_only_a: assert property (state_q.fn[P42][FUNC_W-1:1] == '0 && state_q.fn[P46][FUNC_W-1:1] == '0
    && state_q.fn[P44][FUNC_W-1:1] == '0 && state_q.fn[P45][FUNC_W-1:1] == '0
    && state_q.fn[P56][FUNC_W-1:1] == '0 && state_q.fn[P57][FUNC_W-1:1] == '0)
    else $error("unused bit set in a general-IO-only register");

  analog_switch_a: assert property (1'b1 |=> ANALOG_SWITCH_CLOSE == $past(ANALOG_SWITCH_ENABLE))
    else $error("analog switch does not follow its enable");

endmodule

// ### tb/pad_world_model.sv
// Pad side model: resolves each pad from the block's drive and the outside world
`timescale 1ns/10ps
module pad_world_model
  import pin_function_pkg::*;
(
  // Block side
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] pad_out,
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] pad_oe_n,
  // Outside world
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] ext_drive,
  input  wire logic [pin_function_pkg::PIN_COUNT-1:0] ext_level,
  output      logic [pin_function_pkg::PIN_COUNT-1:0] pad_in
);
  // CEC and both slave lines carry pull-ups
  localparam logic [PIN_COUNT-1:0] PULL_UP = 12'h02c;
  logic wobble = 1'b0;
  // Bare pins wander when nobody drives, so a stale level never passes
  always #10 wobble = ~wobble;
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (!pad_oe_n[i] && ext_drive[i])
        pad_in[i] = pad_out[i] & ext_level[i];
      else if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_drive[i])
        pad_in[i] = ext_level[i];
      else
        pad_in[i] = PULL_UP[i] | wobble;
    end
  end
endmodule

// ### tb/port_pin_function_select_test.sv
// Self-checking bench for the pin function selector
`timescale 1ns/10ps
module port_pin_function_select_test;
  import pin_function_pkg::*;
  localparam logic [PIN_COUNT-1:0][7:0] WANT_MASK = {8'h01, 8'h01, 8'h03, 8'h01, 8'h01, 8'h01,
    8'h03, 8'h01, 8'h03, 8'h07, 8'h03, 8'h03};
  localparam logic [PIN_COUNT-1:0] GP_ONLY = 12'hdd0;
  logic                 mclk = 1'b0;
  logic                 rst_n;
  ahb_req_s             req;
  ahb_req_s             req_in;
  ahb_rsp_s             rsp;
  logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe_n, gpio_out, gpio_drive, gpio_in;
  logic [PIN_COUNT-1:0] ext_drive, ext_level, an_en, an_close;
  periph_out_s          pout;
  periph_in_s           pin;
  logic                 wake;
  logic [31:0]          rd;
  int                   bad_count = 0;
  int                   check_count = 0;

  always #12.5 mclk = ~mclk;
  always_comb begin
    req_in = req;
    req_in.hready = rsp.hreadyout;
  end

  port_pin_function_select i_dut (.MCLK(mclk), .RST_N(rst_n), .AHB_REQ(req_in), .AHB_RSP(rsp),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n), .GPIO_OUT(gpio_out), .GPIO_DRIVE(gpio_drive),
    .GPIO_IN(gpio_in), .PERIPH_OUT(pout), .PERIPH_IN(pin), .STOP_WAKE(wake),
    .ANALOG_SWITCH_ENABLE(an_en), .ANALOG_SWITCH_CLOSE(an_close));
  pad_world_model i_pads (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_drive(ext_drive),
    .ext_level(ext_level), .pad_in(pad_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait; hready sampled before the edge's updates land
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge mclk);
    while (rsp.hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 50) check("hready", 32'h0, 32'h1);
  endtask

  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    req.hsel   <= 1'b1;
    req.haddr  <= {14'h0000, idx, 2'b00};
    req.htrans <= HTRANS_NONSEQ;
    req.hwrite <= wr;
    req.hsize  <= 3'h2;
    wait_ready();
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= {24'h000000, wd};
    wait_ready();
    rd = rsp.hrdata;
  endtask

  // Three edges cover the register, the pad flop and the input flop behind it
  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < PIN_COUNT; i++) begin
      bus(1'b0, PIN_INDEX[i], 8'h00);
      check("reset value", rd, 32'h0);
    end
    check("released pads", pad_oe_n, 12'hfff);
    check("wake idle", wake, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < PIN_COUNT; i++) begin
      // One enable bit per write, bits 3 to 7 always set
      for (int b = 0; b < 3; b++) begin
        bus(1'b1, PIN_INDEX[i], 8'hf8 | (8'h01 << b));
        bus(1'b0, PIN_INDEX[i], 8'h00);
        check("implemented bits", rd, {24'h000000, WANT_MASK[i] & (8'h01 << b)});
      end
    end
    bus(1'b1, 16'ha0d8, 8'hff);
    bus(1'b0, 16'ha0d8, 8'h00);
    check("unmapped read", rd, 32'h0);
    check("unmapped response", rsp.hresp, HRESP_OKAY);
    $display("test registers done");
  endtask

  task automatic t_spi();
    bus(1'b1, PIN_INDEX[P36], 8'h02);
    ext_drive <= 12'h001;
    ext_level <= 12'h001;
    settle();
    check("spi data in high", pin.spi_data_in, 1'b1);
    ext_level <= 12'h000;
    settle();
    check("spi data in low", pin.spi_data_in, 1'b0);
    pout.spi_miso_drive <= 1'b1;
    pout.spi_miso_out   <= 1'b1;
    settle();
    check("miso driven", {pad_oe_n[P36], pad_out[P36]}, 2'b01);
    bus(1'b1, PIN_INDEX[P36], 8'h01);
    ext_level <= 12'h001;
    settle();
    check("p36 general in", gpio_in[P36], 1'b1);
    check("spi data unselected", pin.spi_data_in, 1'b0);
    bus(1'b1, PIN_INDEX[P37], 8'h02);
    pout.spi_clk_drive <= 1'b1;
    pout.spi_clk_out   <= 1'b1;
    settle();
    check("spi clock driven", {pad_oe_n[P37], pad_out[P37], pin.spi_clk_in}, 3'b011);
    pout.spi_clk_drive <= 1'b0;
    ext_drive <= 12'h002;
    ext_level <= 12'h000;
    settle();
    check("spi clock received", {pad_oe_n[P37], pin.spi_clk_in}, 2'b10);
    $display("test spi done");
  endtask

  task automatic t_cec();
    bus(1'b1, PIN_INDEX[P40], 8'h04);
    ext_drive <= 12'h004;
    ext_level <= 12'h000;
    settle();
    check("wake on low", wake, 1'b1);
    ext_level <= 12'h004;
    settle();
    check("no wake on high", wake, 1'b0);
    bus(1'b1, PIN_INDEX[P40], 8'h00);
    ext_level <= 12'h000;
    settle();
    check("wake disabled", wake, 1'b0);
    bus(1'b1, PIN_INDEX[P40], 8'h02);
    ext_drive <= 12'h000;
    pout.cec_drive_low <= 1'b1;
    settle();
    check("cec pulls low", {pad_oe_n[P40], pad_out[P40], pin.cec_in}, 3'b000);
    pout.cec_drive_low <= 1'b0;
    ext_drive <= 12'h004;
    settle();
    check("cec hears low", {pad_oe_n[P40], pin.cec_in, wake}, 3'b101);
    $display("test cec done");
  endtask

  task automatic t_i2c();
    bus(1'b1, PIN_INDEX[P41], 8'h02);
    bus(1'b1, PIN_INDEX[P43], 8'h02);
    ext_drive <= 12'h000;
    pout.sda2_drive_low <= 1'b1;
    settle();
    check("data line low", {pad_oe_n[P41], pad_out[P41], pin.sda2_in}, 3'b000);
    check("clock line released", {pad_oe_n[P43], pin.scl2_in}, 2'b11);
    pout.sda2_drive_low <= 1'b0;
    pout.scl2_drive_low <= 1'b1;
    settle();
    check("clock line low", {pad_oe_n[P43], pad_out[P43], pin.scl2_in}, 3'b000);
    check("data line released", {pad_oe_n[P41], pin.sda2_in}, 2'b11);
    $display("test i2c done");
  endtask

  task automatic t_pwm();
    bus(1'b1, PIN_INDEX[P47], 8'h02);
    for (int v = 0; v < 2; v++) begin
      pout.wide_modulator_output <= v[0];
      settle();
      check("modulator pin", {pad_oe_n[P47], pad_out[P47]}, {1'b0, v[0]});
    end
    $display("test modulator done");
  endtask

  task automatic t_gpio();
    for (int i = 0; i < PIN_COUNT; i++)
      if (GP_ONLY[i]) bus(1'b1, PIN_INDEX[i], 8'h01);
    gpio_drive <= GP_ONLY;
    gpio_out   <= 12'h5a5;
    ext_drive  <= 12'h000;
    settle();
    check("general drive", pad_oe_n & GP_ONLY, 12'h000);
    check("general level", pad_out & GP_ONLY, 12'h5a5 & GP_ONLY);
    gpio_drive <= 12'h000;
    ext_drive  <= 12'hfff;
    ext_level  <= 12'hb5a;
    bus(1'b1, PIN_INDEX[P46], 8'h00);
    settle();
    check("general input", gpio_in & GP_ONLY, 12'hb5a & GP_ONLY & ~12'h100);
    $display("test general io done");
  endtask

  task automatic t_analog();
    bus(1'b1, PIN_INDEX[P56], 8'h00);
    bus(1'b1, PIN_INDEX[P57], 8'h00);
    an_en <= 12'hd00;
    settle();
    check("switches closed", an_close, 12'hd00);
    an_en <= 12'h000;
    settle();
    check("switches open", an_close, 12'h000);
    $display("test analog done");
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    stop_test();
  end

  initial begin
    rst_n      <= 1'b0;
    req        <= '0;
    pout       <= '0;
    gpio_out   <= '0;
    gpio_drive <= '0;
    ext_drive  <= '0;
    ext_level  <= '0;
    an_en      <= '0;
    do_reset();
    t_reset();
    t_regs();
    do_reset();
    t_reset();
    t_spi();
    t_cec();
    t_i2c();
    t_pwm();
    t_gpio();
    t_analog();
    stop_test();
  end
endmodule
